// ---- eatp_parser.sv ----
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "eatp_params.svh"

// How it works
// - Length counts bytes before checksum.
// - Offset 3 must be type 0x11.
// - Echo frame id; zero means silence.
// - Zero radius uses stored hop limit.
// - Zero options use stored default options.
// - Payload from 23, within stored maximum.
// - Checksum is 0xFF minus byte sum.
// - Bit 0 disables unicast acknowledgments.
// - Bit 1 skips mesh route discovery.
// - Bit 3 requests route information frames; bit 2 only on failed transmit.
// - Bit 4 encrypts, payload four less.
// - Bits 7:6 select delivery method.
// - Loopback cluster received is echoed back.
// - Returned loopback gives receive frame.
// - Nonzero id returns extended status frame.
module eatp_parser (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic tx_done,
    input wire logic tx_success,
    input wire logic rx_loop_valid,
    input wire logic [15:0] rx_loop_cluster,
    output logic frame_ok,
    output logic frame_drop,
    output logic payload_valid,
    output logic [7:0] payload_byte,
    output logic status_valid,
    output logic [7:0] status_type,
    output logic [7:0] status_id,
    output logic status_ok,
    output logic route_info_req,
    output logic echo_back,
    output logic host_rx_valid,
    output logic [7:0] host_rx_format,
    output logic ack_req,
    output logic route_disc,
    output logic encrypt,
    output logic [7:0] hop_limit,
    output logic [1:0] delivery
);
    // ***********************************
    // State and register bank
    // ***********************************
    typedef struct packed {
        eatp_pkg::eatp_state_t st;
        logic [15:0] len;
        logic [15:0] pos;
        logic [7:0] sum;
        logic [7:0] fid;
        logic [63:0] dest;
        logic [7:0] src_ep;
        logic [7:0] dst_ep;
        logic [15:0] cluster;
        logic [15:0] profile;
        logic [7:0] radius;
        logic [7:0] opts;
        logic bad_type;
        logic frame_ok;
        logic frame_drop;
        logic payload_valid;
        logic [7:0] payload_byte;
        logic status_valid;
        logic [7:0] status_type;
        logic [7:0] status_id;
        logic status_ok;
        logic route_info_req;
        logic echo_back;
        logic host_rx_valid;
        logic ack_req;
        logic route_disc;
        logic encrypt;
        logic [7:0] hop_limit;
        logic [1:0] delivery;
        logic pend;
        logic [7:0] pend_id;
        logic pend_nack;
        logic pend_trace;
        logic pend_loop;
        logic [15:0] ok_cnt;
        logic [15:0] drop_cnt;
    } eatp_state_s_t;

    eatp_state_s_t s;
    eatp_state_s_t next_s;

    logic [7:0] hops_cfg;
    logic [7:0] opts_cfg;
    logic [15:0] np_cfg;
    logic [7:0] ao_cfg;
    logic [7:0] opts_eff;
    eatp_pkg::eatp_method_t method;
    logic [15:0] pay_limit;
    logic [15:0] pay_len;
    logic [7:0] new_sum;

    eatp_apb_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .status_word({16'h0000, 6'h00, s.delivery, 3'h0, s.pend, 1'b0, s.bad_type,
                      s.frame_drop, s.frame_ok}),
        .frame_word({s.fid, s.radius, s.opts, s.src_ep}),
        .addr_hi(s.dest[63:32]),
        .addr_lo(s.dest[31:0]),
        .app_word({s.cluster, s.profile}),
        .count_word({s.drop_cnt, s.ok_cnt}),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .stored_hop_limit(hops_cfg),
        .default_transmit_options(opts_cfg),
        .max_payload_bytes(np_cfg),
        .receive_output_format(ao_cfg),
        .config_word()
    );

    eatp_opt_decode u_opt (
        .opts_in(s.opts),
        .default_opts(opts_cfg),
        .max_payload(np_cfg),
        .opts_eff(opts_eff),
        .method(method),
        .payload_limit(pay_limit)
    );

    // ***********************************
    // Frame parser
    // ***********************************
    function automatic logic [15:0] eatp_shift16(input logic [15:0] v, input logic [7:0] b);
        eatp_shift16 = {v[7:0], b};
    endfunction

    always_comb begin
        next_s = s;
        pay_len = (s.len > `EATP_HDR_LEN) ? s.len - `EATP_HDR_LEN : 16'h0000;
        new_sum = s.sum + rx_byte;
        next_s.frame_ok = 1'b0;
        next_s.frame_drop = 1'b0;
        next_s.payload_valid = 1'b0;
        next_s.status_valid = 1'b0;
        next_s.route_info_req = 1'b0;
        next_s.echo_back = 1'b0;
        next_s.host_rx_valid = 1'b0;
        if (rx_valid) begin
            case (s.st)
                eatp_pkg::EATP_IDLE: begin
                    if (rx_byte == `EATP_DELIM) begin
                        next_s.st = eatp_pkg::EATP_LEN_HI;
                    end
                end
                eatp_pkg::EATP_LEN_HI: begin
                    next_s.len = {8'h00, rx_byte};
                    next_s.st = eatp_pkg::EATP_LEN_LO;
                end
                eatp_pkg::EATP_LEN_LO: begin
                    next_s.len = eatp_shift16(s.len, rx_byte);
                    next_s.pos = `EATP_OFS_TYPE;
                    next_s.sum = 8'h00;
                    next_s.bad_type = 1'b0;
                    next_s.st = (eatp_shift16(s.len, rx_byte) == 16'h0000) ?
                                eatp_pkg::EATP_CSUM : eatp_pkg::EATP_BODY;
                end
                eatp_pkg::EATP_BODY: begin
                    next_s.sum = new_sum;
                    next_s.pos = s.pos + 16'd1;
                    if (s.pos == `EATP_OFS_TYPE && rx_byte != `EATP_TYPE_EXPLICIT) begin
                        next_s.bad_type = 1'b1;
                    end
                    if (s.pos == `EATP_OFS_ID) begin
                        next_s.fid = rx_byte;
                    end
                    if (s.pos >= `EATP_OFS_DEST && s.pos < `EATP_OFS_RSVD) begin
                        next_s.dest = {s.dest[55:0], rx_byte};
                    end
                    if (s.pos == `EATP_OFS_SRC_EP) begin
                        next_s.src_ep = rx_byte;
                    end
                    if (s.pos == `EATP_OFS_DST_EP) begin
                        next_s.dst_ep = rx_byte;
                    end
                    if (s.pos == `EATP_OFS_CLUSTER || s.pos == `EATP_OFS_CLUSTER + 16'd1) begin
                        next_s.cluster = eatp_shift16(s.cluster, rx_byte);
                    end
                    if (s.pos == `EATP_OFS_PROFILE || s.pos == `EATP_OFS_PROFILE + 16'd1) begin
                        next_s.profile = eatp_shift16(s.profile, rx_byte);
                    end
                    if (s.pos == `EATP_OFS_RADIUS) begin
                        next_s.radius = rx_byte;
                    end
                    if (s.pos == `EATP_OFS_OPTS) begin
                        next_s.opts = rx_byte;
                    end
                    if (s.pos >= `EATP_OFS_PAYLOAD) begin
                        next_s.payload_valid = 1'b1;
                        next_s.payload_byte = rx_byte;
                    end
                    if (s.pos == s.len + 16'd2) begin
                        next_s.st = eatp_pkg::EATP_CSUM;
                    end
                end
                default: begin
                    next_s.st = eatp_pkg::EATP_IDLE;
                    // Discard on bad checksum, method, type, short length or oversized payload.
                    if (new_sum != `EATP_CSUM_BASE || method == eatp_pkg::EATP_DM_INVALID ||
                        s.bad_type || s.len < `EATP_HDR_LEN || pay_len > pay_limit) begin
                        next_s.frame_drop = 1'b1;
                        next_s.drop_cnt = s.drop_cnt + 16'd1;
                    end else begin
                        next_s.frame_ok = 1'b1;
                        next_s.ok_cnt = s.ok_cnt + 16'd1;
                        next_s.ack_req = !opts_eff[`EATP_OPT_NO_ACK];
                        next_s.route_disc = !opts_eff[`EATP_OPT_NO_ROUTE];
                        next_s.encrypt = opts_eff[`EATP_OPT_SECURE];
                        next_s.hop_limit = (s.radius == 8'h00) ? hops_cfg : s.radius;
                        next_s.delivery = method;
                        next_s.pend = 1'b1;
                        next_s.pend_id = s.fid;
                        next_s.pend_nack = opts_eff[`EATP_OPT_NACK];
                        next_s.pend_trace = opts_eff[`EATP_OPT_TRACE];
                        next_s.pend_loop = (s.cluster == `EATP_CLUSTER_LOOPBACK);
                    end
                end
            endcase
        end
        // ***********************************
        // Completion and responses
        // ***********************************
        if (tx_done && s.pend) begin
            // A frame accepted in this same cycle keeps its pending flag.
            next_s.pend = next_s.frame_ok;
            if (s.pend_id != 8'h00) begin
                next_s.status_valid = 1'b1;
                next_s.status_type = `EATP_TYPE_XSTATUS;
                next_s.status_id = s.pend_id;
                next_s.status_ok = tx_success;
            end
            next_s.route_info_req = s.pend_trace || (s.pend_nack && !tx_success);
            next_s.host_rx_valid = s.pend_loop && tx_success;
        end
        if (rx_loop_valid && rx_loop_cluster == `EATP_CLUSTER_LOOPBACK) begin
            next_s.echo_back = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign frame_ok = s.frame_ok;
    assign frame_drop = s.frame_drop;
    assign payload_valid = s.payload_valid;
    assign payload_byte = s.payload_byte;
    assign status_valid = s.status_valid;
    assign status_type = s.status_type;
    assign status_id = s.status_id;
    assign status_ok = s.status_ok;
    assign route_info_req = s.route_info_req;
    assign echo_back = s.echo_back;
    assign host_rx_valid = s.host_rx_valid;
    assign host_rx_format = ao_cfg;
    assign ack_req = s.ack_req;
    assign route_disc = s.route_disc;
    assign encrypt = s.encrypt;
    assign hop_limit = s.hop_limit;
    assign delivery = s.delivery;

    // ***********************************
    // Checks
    // ***********************************
    a_drop_no_ok: assert property (@(posedge pclk) disable iff (!presetn)
        !(frame_ok && frame_drop)) else $error("frame both kept and dropped");
    a_status_id: assert property (@(posedge pclk) disable iff (!presetn)
        status_valid |-> status_id != 8'h00) else $error("status sent for zero id");
    a_status_type: assert property (@(posedge pclk) disable iff (!presetn)
        status_valid |-> status_type == 8'h8b) else $error("wrong status type");
    a_method_valid: assert property (@(posedge pclk) disable iff (!presetn)
        frame_ok |-> delivery != 2'b00) else $error("invalid method accepted");
    a_hop_subst: assert property (@(posedge pclk) disable iff (!presetn)
        frame_ok && $past(s.radius) == 8'h00 |-> hop_limit == $past(hops_cfg))
        else $error("hop limit not substituted");
    a_loop_echo: assert property (@(posedge pclk) disable iff (!presetn)
        rx_loop_valid && rx_loop_cluster == 16'h0012 |=> echo_back)
        else $error("loopback not echoed");
    a_ack_bit: assert property (@(posedge pclk) disable iff (!presetn)
        frame_ok |-> ack_req == !$past(opts_eff[0])) else $error("ack bit wrong");
    a_route_bit: assert property (@(posedge pclk) disable iff (!presetn)
        frame_ok |-> route_disc == !$past(opts_eff[1])) else $error("route bit wrong");
    c_ok: cover property (@(posedge pclk) disable iff (!presetn) frame_ok);
    c_drop: cover property (@(posedge pclk) disable iff (!presetn) frame_drop);
    c_status: cover property (@(posedge pclk) disable iff (!presetn) status_valid);
    c_loop: cover property (@(posedge pclk) disable iff (!presetn) host_rx_valid);
endmodule // eatp_parser

`default_nettype wire

// ---- eatp_params.svh ----
`ifndef EATP_PARAMS_SVH
`define EATP_PARAMS_SVH

// Frame layout.
`define EATP_DELIM 8'h7e
`define EATP_TYPE_EXPLICIT 8'h11
`define EATP_OFS_TYPE 16'd3
`define EATP_OFS_ID 16'd4
`define EATP_OFS_DEST 16'd5
`define EATP_OFS_RSVD 16'd13
`define EATP_OFS_SRC_EP 16'd15
`define EATP_OFS_DST_EP 16'd16
`define EATP_OFS_CLUSTER 16'd17
`define EATP_OFS_PROFILE 16'd19
`define EATP_OFS_RADIUS 16'd21
`define EATP_OFS_OPTS 16'd22
`define EATP_OFS_PAYLOAD 16'd23
`define EATP_HDR_LEN 16'd20
`define EATP_CSUM_BASE 8'hff

// Option bits.
`define EATP_OPT_NO_ACK 0
`define EATP_OPT_NO_ROUTE 1
`define EATP_OPT_NACK 2
`define EATP_OPT_TRACE 3
`define EATP_OPT_SECURE 4
`define EATP_SECURE_OVERHEAD 16'd4

// Special values.
`define EATP_CLUSTER_LOOPBACK 16'h0012
`define EATP_BCAST_ADDR 64'h000000000000ffff
`define EATP_TYPE_ROUTE_INFO 8'h8d
`define EATP_TYPE_XSTATUS 8'h8b

// Register map.
`define EATP_REG_CTRL 12'h000
`define EATP_REG_CONFIG 12'h004
`define EATP_REG_STATUS 12'h008
`define EATP_REG_FRAME 12'h00c
`define EATP_REG_ADDR_HI 12'h010
`define EATP_REG_ADDR_LO 12'h014
`define EATP_REG_APP 12'h018
`define EATP_REG_COUNTS 12'h01c

// Reset values.
`define EATP_RST_HOPS 8'h00
`define EATP_RST_OPTS 8'hc0
`define EATP_RST_NP 16'h0100
`define EATP_RST_AO 8'h00

`endif

// ---- eatp_pkg.sv ----
package eatp_pkg;

    typedef enum logic [3:0] {
        EATP_IDLE = 4'b0000,
        EATP_LEN_HI = 4'b0001,
        EATP_LEN_LO = 4'b0010,
        EATP_BODY = 4'b0011,
        EATP_CSUM = 4'b0100
    } eatp_state_t;

    typedef enum logic [1:0] {
        EATP_DM_INVALID = 2'b00,
        EATP_DM_P2MP = 2'b01,
        EATP_DM_DIRECTED = 2'b10,
        EATP_DM_MESH = 2'b11
    } eatp_method_t;

endpackage

// ---- eatp_opt_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "eatp_params.svh"

module eatp_opt_decode (
    input wire logic [7:0] opts_in,
    input wire logic [7:0] default_opts,
    input wire logic [15:0] max_payload,
    output logic [7:0] opts_eff,
    output eatp_pkg::eatp_method_t method,
    output logic [15:0] payload_limit
);
    always_comb begin
        opts_eff = (opts_in == 8'h00) ? default_opts : opts_in;
        method = eatp_pkg::eatp_method_t'(opts_eff[7:6]);
        if (opts_eff[`EATP_OPT_SECURE] && max_payload >= `EATP_SECURE_OVERHEAD) begin
            payload_limit = max_payload - `EATP_SECURE_OVERHEAD;
        end else if (opts_eff[`EATP_OPT_SECURE]) begin
            payload_limit = 16'h0000;
        end else begin
            payload_limit = max_payload;
        end
    end
endmodule // eatp_opt_decode

`default_nettype wire

// ---- eatp_apb_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "eatp_params.svh"

module eatp_apb_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] status_word,
    input wire logic [31:0] frame_word,
    input wire logic [31:0] addr_hi,
    input wire logic [31:0] addr_lo,
    input wire logic [31:0] app_word,
    input wire logic [31:0] count_word,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] stored_hop_limit,
    output logic [7:0] default_transmit_options,
    output logic [15:0] max_payload_bytes,
    output logic [7:0] receive_output_format,
    output logic [31:0] config_word
);
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [7:0] hops;
        logic [7:0] opts;
        logic [15:0] np;
        logic [7:0] ao;
    } eatp_regs_t;

    eatp_regs_t r;
    eatp_regs_t next_r;
    logic access;

    always_comb begin
        next_r = r;
        access = psel && !penable;
        next_r.pready = access;
        next_r.pslverr = 1'b0;
        if (access) begin
            next_r.prdata = 32'h0000_0000;
            if (paddr == `EATP_REG_CTRL) begin
                next_r.prdata = {8'h00, r.ao, r.opts, r.hops};
            end else if (paddr == `EATP_REG_CONFIG) begin
                next_r.prdata = {16'h0000, r.np};
            end else if (paddr == `EATP_REG_STATUS) begin
                next_r.prdata = status_word;
            end else if (paddr == `EATP_REG_FRAME) begin
                next_r.prdata = frame_word;
            end else if (paddr == `EATP_REG_ADDR_HI) begin
                next_r.prdata = addr_hi;
            end else if (paddr == `EATP_REG_ADDR_LO) begin
                next_r.prdata = addr_lo;
            end else if (paddr == `EATP_REG_APP) begin
                next_r.prdata = app_word;
            end else if (paddr == `EATP_REG_COUNTS) begin
                next_r.prdata = count_word;
            end else begin
                next_r.pslverr = 1'b1;
            end
        end
        // Writes land only at the edge that completes the access phase.
        if (psel && penable && r.pready && pwrite) begin
            if (paddr == `EATP_REG_CTRL) begin
                next_r.hops = pwdata[7:0];
                next_r.opts = pwdata[15:8];
                next_r.ao = pwdata[23:16];
            end else if (paddr == `EATP_REG_CONFIG) begin
                next_r.np = pwdata[15:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0,
                   hops: `EATP_RST_HOPS, opts: `EATP_RST_OPTS,
                   np: `EATP_RST_NP, ao: `EATP_RST_AO};
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign stored_hop_limit = r.hops;
    assign default_transmit_options = r.opts;
    assign max_payload_bytes = r.np;
    assign receive_output_format = r.ao;
    assign config_word = {16'h0000, r.np};
endmodule // eatp_apb_regs

`default_nettype wire

// ---- eatp_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module eatp_host_model #(
    // Arbitrary profile value, not tied to any vendor.
    parameter logic [15:0] PROFILE_ID = 16'h5a3c
) (
    input wire logic pclk,
    output logic rx_valid,
    output logic [7:0] rx_byte
);
    logic [7:0] q[$];
    logic [7:0] sum;
    int n;
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
    end
    task automatic send(input logic [7:0] id, input logic [7:0] opts, input logic [7:0] rad,
                        input logic [15:0] cl, input int np, input logic bad, input logic slow);
        logic [63:0] dest;
        // Broadcast when a radius is given, else 16-bit addressing.
        dest = (rad != 8'h00) ? 64'h0000_0000_0000_ffff : 64'hffff_ffff_ffff_ffff;
        q = '{8'h11, id, dest[63:56], dest[55:48], dest[47:40], dest[39:32], dest[31:24],
              dest[23:16], dest[15:8], dest[7:0], 8'hff, 8'hfe,
              8'he8, 8'he8, cl[15:8], cl[7:0], PROFILE_ID[15:8], PROFILE_ID[7:0], rad, opts};
        for (int i = 0; i < np; i++) q.push_back(8'h30 + i[7:0]);
        sum = 8'h00;
        foreach (q[i]) sum += q[i];
        n = q.size();
        q.push_back((8'hff - sum) ^ {7'h00, bad});
        // delimiter and length, most significant byte first.
        q.push_front(n[7:0]);
        q.push_front(n[15:8]);
        q.push_front(8'h7e);
        foreach (q[i]) begin
            @(posedge pclk);
            rx_valid <= 1'b1;
            rx_byte <= q[i];
            if (slow) begin
                @(posedge pclk);
                rx_valid <= 1'b0;
                rx_byte <= ~q[i];
            end
        end
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_byte <= ~rx_byte;
    endtask
endmodule // eatp_host_model
`default_nettype wire

// ---- explicit_addr_tx_frame_parser_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module explicit_addr_tx_frame_parser_tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, rx_valid, tx_done = 1'b0, tx_success = 1'b0;
    logic rx_loop_valid = 1'b0;
    logic [15:0] rx_loop_cluster = 16'h0000;
    logic [7:0] rx_byte, payload_byte, status_type, status_id, host_rx_format, hop_limit;
    logic frame_ok, frame_drop, payload_valid, status_valid, status_ok, route_info_req;
    logic echo_back, host_rx_valid, ack_req, route_disc, encrypt;
    logic [1:0] delivery;
    logic [7:0] pay_q[$];
    logic [7:0] st_type, st_id;
    logic st_ok;
    int n_mismatch = 0, n_compared = 0, n_ok, n_drop, n_stat, n_route, n_hrx, n_echo;
    always #10 pclk = ~pclk;
    eatp_host_model u_host (.pclk(pclk), .rx_valid(rx_valid), .rx_byte(rx_byte));
    eatp_parser u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_done(tx_done),
        .tx_success(tx_success), .rx_loop_valid(rx_loop_valid),
        .rx_loop_cluster(rx_loop_cluster), .frame_ok(frame_ok), .frame_drop(frame_drop),
        .payload_valid(payload_valid), .payload_byte(payload_byte),
        .status_valid(status_valid), .status_type(status_type), .status_id(status_id),
        .status_ok(status_ok), .route_info_req(route_info_req), .echo_back(echo_back),
        .host_rx_valid(host_rx_valid), .host_rx_format(host_rx_format), .ack_req(ack_req),
        .route_disc(route_disc), .encrypt(encrypt), .hop_limit(hop_limit),
        .delivery(delivery));
    always @(posedge pclk) begin
        if (payload_valid === 1'b1) pay_q.push_back(payload_byte);
        if (frame_ok === 1'b1) n_ok++;
        if (frame_drop === 1'b1) n_drop++;
        if (route_info_req === 1'b1) n_route++;
        if (host_rx_valid === 1'b1) n_hrx++;
        if (echo_back === 1'b1) n_echo++;
        if (status_valid === 1'b1) begin
            n_stat++;
            st_type = status_type;
            st_id = status_id;
            st_ok = status_ok;
        end
    end
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk(pready, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic frame(input logic [7:0] id, input logic [7:0] op, input logic [7:0] rad,
                         input logic [15:0] cl, input int np, input logic bad, input logic ok);
        n_ok = 0;
        n_drop = 0;
        pay_q.delete();
        u_host.send(id, op, rad, cl, np, bad, np[0]);
        repeat (3) @(posedge pclk);
        chk(n_ok, ok);
        chk(n_drop, !ok);
        if (ok) chk(pay_q.size(), np);
        foreach (pay_q[i]) if (ok) chk(pay_q[i], 8'h30 + i);
    endtask
    task automatic tx(input logic s);
        n_stat = 0;
        n_route = 0;
        n_hrx = 0;
        @(posedge pclk);
        tx_done <= 1'b1;
        tx_success <= s;
        @(posedge pclk);
        tx_done <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    task automatic loop(input logic [15:0] cl, input int exp);
        n_echo = 0;
        @(posedge pclk);
        rx_loop_valid <= 1'b1;
        rx_loop_cluster <= cl;
        @(posedge pclk);
        rx_loop_valid <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(n_echo, exp);
    endtask
    initial begin
        #1_000_000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0000c000);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h00000100);
        apb(1'b0, 12'h020, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, 12'h000, 32'h0090c005);
        frame(8'h87, 8'h00, 8'h00, 16'h0011, 6, 1'b0, 1'b1);
        chk({hop_limit, delivery, ack_req, route_disc, encrypt}, 13'h00be);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'hffffffff);
        apb(1'b0, 12'h014, 32'h0);
        chk(rd, 32'hffffffff);
        tx(1'b1);
        chk({n_stat, st_type, st_id, st_ok, n_route}, {32'd1, 8'h8b, 8'h87, 1'b1, 32'd0});
        frame(8'h00, 8'h47, 8'h03, 16'h0011, 5, 1'b0, 1'b1);
        chk({hop_limit, delivery, ack_req, route_disc}, 12'h034);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h00000000);
        apb(1'b0, 12'h014, 32'h0);
        chk(rd, 32'h0000ffff);
        tx(1'b0);
        chk({n_stat, n_route}, {32'd0, 32'd1});
        frame(8'h21, 8'h88, 8'h00, 16'h0011, 2, 1'b0, 1'b1);
        chk(delivery, 2'b10);
        tx(1'b1);
        chk({n_stat, st_id, n_route}, {32'd1, 8'h21, 32'd1});
        frame(8'h22, 8'hc0, 8'h00, 16'h0011, 3, 1'b1, 1'b0);
        frame(8'h23, 8'h01, 8'h00, 16'h0011, 3, 1'b0, 1'b0);
        apb(1'b1, 12'h004, 32'h00000006);
        frame(8'h24, 8'hd0, 8'h00, 16'h0011, 2, 1'b0, 1'b1);
        chk(encrypt, 1'b1);
        frame(8'h25, 8'hd0, 8'h00, 16'h0011, 3, 1'b0, 1'b0);
        frame(8'h26, 8'hc0, 8'h00, 16'h0011, 6, 1'b0, 1'b1);
        frame(8'h27, 8'hc0, 8'h00, 16'h0011, 7, 1'b0, 1'b0);
        frame(8'hf8, 8'hc1, 8'h00, 16'h0012, 6, 1'b0, 1'b1);
        tx(1'b1);
        chk({n_hrx, host_rx_format}, {32'd1, 8'h90});
        loop(16'h0012, 1);
        loop(16'h0011, 0);
        apb(1'b0, 12'h018, 32'h0);
        chk(rd, 32'h00125a3c);
        apb(1'b0, 12'h01c, 32'h0);
        chk(rd, 32'h00040006);
        end_of_test();
    end
endmodule // explicit_addr_tx_frame_parser_tb
`default_nettype wire
